// ### design/csr_map.svh
// register indices, field positions and reset values of the color sensor readout
// What this block does
// - status register ignores all host writes
// - front end saturation sets status bit 7
// - saturation clears on clear-channel command or disable
// - saturation interrupts only with its enable set
// - saturation enable is auxiliary bit 5
// - threshold crossing with persistence sets status bit 4
// - persistence code maps to consecutive out-of-range counts
// - completed cycle after enable sets status bit 0
// - clear, red, green, blue as byte pairs
// - low read copies high byte into shadow
// - shadow holds across later conversion cycles
// - routing bit 7 puts infrared on clear
// - any written byte acts as the command
// - force write asserts an interrupt
// - clear-channel clear write drops clear-channel interrupts
// - clear-all write drops every pending interrupt
// - clear compared against byte-built low/high thresholds
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CSR_IDX_ENABLE 8'h80
`define CSR_IDX_LOW_THR_L 8'h84
`define CSR_IDX_LOW_THR_H 8'h85
`define CSR_IDX_HIGH_THR_L 8'h86
`define CSR_IDX_HIGH_THR_H 8'h87
`define CSR_IDX_PERSIST 8'h8C
`define CSR_IDX_AUX 8'h90
`define CSR_IDX_STATUS 8'h93
`define CSR_IDX_CLEAR_L 8'h94
`define CSR_IDX_CLEAR_H 8'h95
`define CSR_IDX_RED_L 8'h96
`define CSR_IDX_RED_H 8'h97
`define CSR_IDX_GREEN_L 8'h98
`define CSR_IDX_GREEN_H 8'h99
`define CSR_IDX_BLUE_L 8'h9A
`define CSR_IDX_BLUE_H 8'h9B
`define CSR_IDX_IR_ROUTE 8'hC0
`define CSR_IDX_FORCE 8'hE4
`define CSR_IDX_CLR_CHAN 8'hE6
`define CSR_IDX_CLR_ALL 8'hE7

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CSR_BIT_ENABLE 0
`define CSR_BIT_SAT 7
`define CSR_BIT_LIGHT 4
`define CSR_BIT_VALID 0
`define CSR_BIT_SAT_IEN 5
`define CSR_BIT_IR_ROUTE 7
`define CSR_RST_BYTE 8'h00
`define CSR_RST_WORD 16'h0000
`define CSR_PERS_STEP 6'h05
`define CSR_PERS_BASE 4'h3
`define CSR_CNT_MAX 6'h3F

`endif

// ### design/csr_pkg.sv
// types shared by the color sensor readout
package csr_pkg;

    // ----------------------------------------------------------------
    // bus request captured in the address phase
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] idx;
        logic mapped;
        logic write;
    } csr_req_t;

    // ----------------------------------------------------------------
    // one completed color measurement cycle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] clear;
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] blue;
        logic [15:0] ir;
    } csr_result_t;

    typedef enum logic {
        CSR_BUS_IDLE,
        CSR_BUS_DATA
    } csr_bus_state_t;

endpackage

// ### design/csr_readout.sv
// color sensor status and result readout behind an AHB-Lite slave
`timescale 1ns/1ps
`include "csr_map.svh"

module csr_readout
    import csr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic cycle_done,
    input wire csr_result_t result_in,
    input wire logic sat_event,
    output logic measurement_enable,
    output logic int_n_o,
    output logic int_n_oe
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_low_result(input logic [7:0] idx);
        is_low_result = (idx == `CSR_IDX_CLEAR_L) || (idx == `CSR_IDX_RED_L) ||
                        (idx == `CSR_IDX_GREEN_L) || (idx == `CSR_IDX_BLUE_L);
    endfunction

    // persistence code to the number of consecutive out-of-range cycles
    function automatic logic [5:0] pers_needed(input logic [3:0] code);
        logic [5:0] steps;
        steps = {2'b00, code - `CSR_PERS_BASE};
        if (code <= `CSR_PERS_BASE) begin
            pers_needed = {2'b00, code};
        end else if (code == 4'h4) begin
            pers_needed = `CSR_PERS_STEP;
        end else begin
            pers_needed = 6'(steps * `CSR_PERS_STEP);
        end
    endfunction

    csr_bus_state_t state;
    csr_req_t req;
    csr_result_t res;
    logic [7:0] low_thr_l;
    logic [7:0] low_thr_h;
    logic [7:0] high_thr_l;
    logic [7:0] high_thr_h;
    logic [3:0] persistence_count;
    logic saturation_irq_enable;
    logic ir_route;
    logic saturation_flag;
    logic light_threshold_flag;
    logic cycle_valid_flag;
    logic force_flag;
    logic [7:0] shadow;
    logic [5:0] out_cnt;
    logic [7:0] next_rdata;
    logic accept;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic cmd_force;
    logic cmd_clr_chan;
    logic cmd_clr_all;
    logic meas_cycle;
    logic out_of_range;
    logic light_hit;
    logic [5:0] next_cnt;
    logic [15:0] reported_clear;

    assign accept = hsel && htrans[1] && hready && (state == CSR_BUS_IDLE);
    assign wr_fire = (state == CSR_BUS_DATA) && req.write && req.mapped;
    assign rd_fire = (state == CSR_BUS_DATA) && !req.write;
    assign wbyte = hwdata[7:0];
    // the written byte itself is never looked at
    // any byte commands
    assign cmd_force = wr_fire && (req.idx == `CSR_IDX_FORCE);
    assign cmd_clr_chan = wr_fire && (req.idx == `CSR_IDX_CLR_CHAN);
    assign cmd_clr_all = wr_fire && (req.idx == `CSR_IDX_CLR_ALL);
    assign meas_cycle = cycle_done && measurement_enable;
    assign reported_clear = ir_route ? res.ir : res.clear;

    // ----------------------------------------------------------------
    // bus slave: one wait state, then the answer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= CSR_BUS_IDLE;
            req <= '0;
        end else begin
            unique case (state)
                CSR_BUS_IDLE: begin
                    if (accept) begin
                        state <= CSR_BUS_DATA;
                        req.idx <= haddr[9:2];
                        req.mapped <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
                        req.write <= hwrite;
                    end
                end
                CSR_BUS_DATA: begin
                    state <= CSR_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= !accept;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= 32'h00000000;
        end else if (rd_fire) begin
            hrdata <= {24'h000000, req.mapped ? next_rdata : `CSR_RST_BYTE};
        end
    end

    // ----------------------------------------------------------------
    // read multiplexer
    // ----------------------------------------------------------------
    // control, status and result byte registers
    always_comb begin
        next_rdata = `CSR_RST_BYTE;
        unique case (req.idx)
            `CSR_IDX_ENABLE: next_rdata[`CSR_BIT_ENABLE] = measurement_enable;
            `CSR_IDX_LOW_THR_L: next_rdata = low_thr_l;
            `CSR_IDX_LOW_THR_H: next_rdata = low_thr_h;
            `CSR_IDX_HIGH_THR_L: next_rdata = high_thr_l;
            `CSR_IDX_HIGH_THR_H: next_rdata = high_thr_h;
            `CSR_IDX_PERSIST: next_rdata = {4'h0, persistence_count};
            `CSR_IDX_AUX: next_rdata[`CSR_BIT_SAT_IEN] = saturation_irq_enable;
            `CSR_IDX_STATUS: begin
                next_rdata[`CSR_BIT_SAT] = saturation_flag;
                next_rdata[`CSR_BIT_LIGHT] = light_threshold_flag;
                next_rdata[`CSR_BIT_VALID] = cycle_valid_flag;
            end
            `CSR_IDX_CLEAR_L: next_rdata = reported_clear[7:0];
            `CSR_IDX_RED_L: next_rdata = res.red[7:0];
            `CSR_IDX_GREEN_L: next_rdata = res.green[7:0];
            `CSR_IDX_BLUE_L: next_rdata = res.blue[7:0];
            `CSR_IDX_CLEAR_H, `CSR_IDX_RED_H, `CSR_IDX_GREEN_H, `CSR_IDX_BLUE_H: next_rdata = shadow;
            `CSR_IDX_IR_ROUTE: next_rdata[`CSR_BIT_IR_ROUTE] = ir_route;
            default: next_rdata = `CSR_RST_BYTE;
        endcase
    end

    // ----------------------------------------------------------------
    // writable control registers
    // ----------------------------------------------------------------
    // status not writable
    always_ff @(posedge clk) begin
        if (srst) begin
            measurement_enable <= 1'b0;
            low_thr_l <= `CSR_RST_BYTE;
            low_thr_h <= `CSR_RST_BYTE;
            high_thr_l <= `CSR_RST_BYTE;
            high_thr_h <= `CSR_RST_BYTE;
            persistence_count <= 4'h0;
            saturation_irq_enable <= 1'b0;
            ir_route <= 1'b0;
        end else if (wr_fire) begin
            if (req.idx == `CSR_IDX_ENABLE) measurement_enable <= wbyte[`CSR_BIT_ENABLE];
            if (req.idx == `CSR_IDX_LOW_THR_L) low_thr_l <= wbyte;
            if (req.idx == `CSR_IDX_LOW_THR_H) low_thr_h <= wbyte;
            if (req.idx == `CSR_IDX_HIGH_THR_L) high_thr_l <= wbyte;
            if (req.idx == `CSR_IDX_HIGH_THR_H) high_thr_h <= wbyte;
            if (req.idx == `CSR_IDX_PERSIST) persistence_count <= wbyte[3:0];
            if (req.idx == `CSR_IDX_AUX) saturation_irq_enable <= wbyte[`CSR_BIT_SAT_IEN];
            if (req.idx == `CSR_IDX_IR_ROUTE) ir_route <= wbyte[`CSR_BIT_IR_ROUTE];
        end
    end

    // ----------------------------------------------------------------
    // results and shadow latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            res <= '0;
        end else if (meas_cycle) begin
            res <= result_in;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shadow <= `CSR_RST_BYTE;
        end else if (rd_fire && req.mapped && is_low_result(req.idx)) begin
            unique case (req.idx)
                `CSR_IDX_CLEAR_L: shadow <= reported_clear[15:8];
                `CSR_IDX_RED_L: shadow <= res.red[15:8];
                `CSR_IDX_GREEN_L: shadow <= res.green[15:8];
                default: shadow <= res.blue[15:8];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // threshold and persistence
    // ----------------------------------------------------------------
    // sixteen bit thresholds
    assign out_of_range = (result_in.clear < {low_thr_h, low_thr_l}) ||
                          (result_in.clear > {high_thr_h, high_thr_l});
    assign next_cnt = (out_cnt == `CSR_CNT_MAX) ? out_cnt : out_cnt + 6'h01;
    assign light_hit = meas_cycle && ((persistence_count == 4'h0) ||
                       (out_of_range && (next_cnt >= pers_needed(persistence_count))));

    always_ff @(posedge clk) begin
        if (srst || !measurement_enable) begin
            out_cnt <= 6'h00;
        end else if (meas_cycle) begin
            out_cnt <= out_of_range ? next_cnt : 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // status flags: a set in the same cycle beats a clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            saturation_flag <= 1'b0;
        end else if (sat_event && measurement_enable) begin
            saturation_flag <= 1'b1;
        end else if (cmd_clr_chan || cmd_clr_all || !measurement_enable) begin
            saturation_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            light_threshold_flag <= 1'b0;
        end else if (light_hit) begin
            light_threshold_flag <= 1'b1;
        end else if (cmd_clr_chan || cmd_clr_all) begin
            light_threshold_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !measurement_enable) begin
            cycle_valid_flag <= 1'b0;
        end else if (meas_cycle) begin
            cycle_valid_flag <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            force_flag <= 1'b0;
        end else if (cmd_force) begin
            force_flag <= 1'b1;
        end else if (cmd_clr_all) begin
            force_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // open-drain interrupt pin
    // ----------------------------------------------------------------
    // gated saturation source
    always_ff @(posedge clk) begin
        if (srst) begin
            int_n_o <= 1'b0;
            int_n_oe <= 1'b0;
        end else begin
            int_n_o <= 1'b0;
            int_n_oe <= light_threshold_flag || force_flag || (saturation_flag && saturation_irq_enable);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_status_ro: assert property (wr_fire && req.idx == `CSR_IDX_STATUS && !sat_event && !meas_cycle
        && measurement_enable |=> $stable(saturation_flag) && $stable(light_threshold_flag))
        else $error("status changed by a write");
    a_sat_set: assert property (sat_event && measurement_enable |=> saturation_flag)
        else $error("saturation not flagged");
    a_sat_disable: assert property (!measurement_enable |=> !saturation_flag && !cycle_valid_flag)
        else $error("flags kept while disabled");
    a_sat_gate: assert property (saturation_flag && !saturation_irq_enable && !light_threshold_flag
        && !force_flag |=> !int_n_oe)
        else $error("ungated saturation interrupt");
    a_pers_every: assert property (meas_cycle && persistence_count == 4'h0 |=> light_threshold_flag)
        else $error("persistence zero did not flag");
    a_valid_set: assert property (meas_cycle |=> cycle_valid_flag)
        else $error("valid not set after cycle");
    a_shadow_copy: assert property (rd_fire && req.mapped && req.idx == `CSR_IDX_RED_L
        |=> shadow == $past(res.red[15:8]))
        else $error("shadow not loaded");
    a_shadow_hold: assert property (!(rd_fire && is_low_result(req.idx)) |=> $stable(shadow))
        else $error("shadow moved without low read");
    a_force_pin: assert property (cmd_force |=> force_flag ##1 int_n_oe && !int_n_o)
        else $error("force did not drive pin");
    a_clear_all: assert property (cmd_clr_all && !light_hit && !sat_event |=> !light_threshold_flag
        && !force_flag && !saturation_flag)
        else $error("clear-all left a flag");
    a_rsvd_zero: assert property (rd_fire && req.idx == `CSR_IDX_STATUS
        |=> hrdata[6:5] == 2'b00 && hrdata[3:1] == 3'b000)
        else $error("reserved status bits set");
    a_bus_wait: assert property (accept |=> !hreadyout ##1 hreadyout && !hresp)
        else $error("bus answer timing wrong");
    a_light_set: assert property (light_hit |=> light_threshold_flag)
        else $error("threshold event not flagged");
    a_pers_hold: assert property (meas_cycle && !out_of_range && persistence_count != 4'h0
        && !light_threshold_flag |=> !light_threshold_flag)
        else $error("in-range cycle flagged");
    a_sat_enable: assert property (wr_fire && req.idx == `CSR_IDX_AUX
        |=> saturation_irq_enable == $past(wbyte[`CSR_BIT_SAT_IEN]))
        else $error("saturation enable not stored");
    a_ir_route: assert property (rd_fire && req.mapped && req.idx == `CSR_IDX_CLEAR_L && ir_route
        |=> hrdata[7:0] == $past(res.ir[7:0]))
        else $error("infrared not routed to clear");
    a_pair_high: assert property (rd_fire && req.mapped && req.idx == `CSR_IDX_CLEAR_H
        |=> hrdata[7:0] == $past(shadow))
        else $error("high byte not from shadow");
    a_chan_clear: assert property (cmd_clr_chan && !light_hit && !sat_event
        |=> !light_threshold_flag && !saturation_flag)
        else $error("clear-channel command left a flag");
    a_force_hold: assert property (force_flag && !cmd_clr_all |=> force_flag)
        else $error("forced interrupt dropped early");
    a_pin_drive: assert property (light_threshold_flag || force_flag
        || (saturation_flag && saturation_irq_enable) |=> int_n_oe && !int_n_o)
        else $error("pending source did not drive pin");
    a_pin_release: assert property (!light_threshold_flag && !force_flag
        && !saturation_flag |=> !int_n_oe)
        else $error("pin driven with nothing pending");
    a_route_rsvd: assert property (rd_fire && req.idx == `CSR_IDX_IR_ROUTE |=> hrdata[6:0] == 7'h00)
        else $error("reserved routing bits set");

    c_force_irq: cover property (cmd_force ##2 int_n_oe);
    c_shadow_pair: cover property (rd_fire && req.idx == `CSR_IDX_CLEAR_L ##[1:20] rd_fire && req.idx == `CSR_IDX_CLEAR_H);
    c_light_hit: cover property (light_hit && persistence_count != 4'h0);
    c_sat_irq: cover property (saturation_flag && saturation_irq_enable ##1 int_n_oe);
    c_pers_sixty: cover property (light_hit && persistence_count == 4'hF);

endmodule

// ### tb/csr_front_model.sv
// front end stand-in that delivers measurement cycles to the readout
`timescale 1ns/1ps

module csr_front_model
    import csr_pkg::*;
(
    input wire logic clk,
    input wire logic measurement_enable,
    output logic cycle_done,
    output csr_result_t result_in,
    output logic sat_event
);
    // ----------------------------------------------------------------
    // measurement cycle delivery
    // ----------------------------------------------------------------
    initial begin
        cycle_done = 1'b0;
        sat_event = 1'b0;
        result_in = '0;
    end

    // gap sets how slowly the cycle arrives; an idle front end sends nothing
    task automatic conv(input csr_result_t r, input logic sat, input int gap);
        repeat (gap) @(negedge clk);
        if (measurement_enable === 1'b1) begin
            @(posedge clk);
            cycle_done <= 1'b1;
            result_in <= r;
            sat_event <= sat;
            @(posedge clk);
            cycle_done <= 1'b0;
            sat_event <= 1'b0;
            // result bus carries nothing useful outside the pulse
            result_in <= ~r;
        end
    endtask
endmodule

// ### tb/csr_readout_tb_top.sv
// self-checking bench for the color sensor readout
`timescale 1ns/1ps
`include "csr_map.svh"

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; $display("FAIL %s expected %h seen %h", nm, ex, got); end end

module csr_readout_tb_top
    import csr_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic cycle_done;
    logic sat_event;
    logic measurement_enable;
    logic int_n_o;
    logic int_n_oe;
    csr_result_t result_in;
    csr_result_t r, in_r, out_r;
    int fails = 0;
    int checked = 0;

    always #20 clk = ~clk;

    csr_readout i_dut (.clk(clk), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .cycle_done(cycle_done), .result_in(result_in), .sat_event(sat_event),
        .measurement_enable(measurement_enable), .int_n_o(int_n_o), .int_n_oe(int_n_oe));

    csr_front_model i_fe (.clk(clk), .measurement_enable(measurement_enable), .cycle_done(cycle_done),
        .result_in(result_in), .sat_event(sat_event));

    // ----------------------------------------------------------------
    // bus and report helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n = 0;
        @(posedge clk);
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
        rd = hrdata[7:0];
        `CHK("hresp", 1'b0, hresp)
        if (!wr) `CHK("hrdata upper", 24'h000000, hrdata[31:8])
        if (n >= 100) begin
            fails++;
            $display("FAIL bus wait expected hready seen timeout");
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, d);
        `CHK(nm, ex, d)
    endtask

    task automatic pin_chk(input logic ex);
        repeat (3) @(negedge clk);
        `CHK("int_n_oe", ex, int_n_oe)
        `CHK("int_n_o", 1'b0, int_n_o)
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        `CHK("enable", 1'b0, measurement_enable)
        rd_chk(`CSR_IDX_STATUS, 8'h00, "status");
        rd_chk(`CSR_IDX_IR_ROUTE, 8'h00, "ir route");
        pin_chk(1'b0);
    endtask

    task automatic t_access();
        wr(`CSR_IDX_ENABLE, 8'h01);
        `CHK("enable", 1'b1, measurement_enable)
        wr(`CSR_IDX_STATUS, 8'hFF);
        rd_chk(`CSR_IDX_STATUS, 8'h00, "status ro");
        rd_chk(8'hA5, 8'h00, "unmapped");
        rd_chk(`CSR_IDX_FORCE, 8'h00, "force read");
    endtask

    task automatic t_results();
        r = {16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0F1E};
        wr(`CSR_IDX_HIGH_THR_L, 8'hFF);
        wr(`CSR_IDX_HIGH_THR_H, 8'hFF);
        wr(`CSR_IDX_PERSIST, 8'h01);
        i_fe.conv(r, 1'b0, 1);
        rd_chk(`CSR_IDX_STATUS, 8'h01, "status valid");
        for (int i = 0; i < 4; i++) begin
            rd_chk(`CSR_IDX_CLEAR_L + 8'(2 * i), r[71 - 16 * i -: 8], "low byte");
            rd_chk(`CSR_IDX_CLEAR_H + 8'(2 * i), r[79 - 16 * i -: 8], "high byte");
        end
    endtask

    task automatic t_shadow();
        rd_chk(`CSR_IDX_CLEAR_L, 8'h34, "clear low");
        r.clear = 16'hAB55;
        i_fe.conv(r, 1'b0, 3);
        rd_chk(`CSR_IDX_CLEAR_H, 8'h12, "held high");
        rd_chk(`CSR_IDX_CLEAR_L, 8'h55, "new low");
        rd_chk(`CSR_IDX_CLEAR_H, 8'hAB, "new high");
    endtask

    task automatic t_ir();
        wr(`CSR_IDX_IR_ROUTE, 8'h80);
        rd_chk(`CSR_IDX_IR_ROUTE, 8'h80, "ir route");
        i_fe.conv(r, 1'b0, 1);
        rd_chk(`CSR_IDX_CLEAR_L, 8'h1E, "ir low");
        rd_chk(`CSR_IDX_CLEAR_H, 8'h0F, "ir high");
        wr(`CSR_IDX_IR_ROUTE, 8'h00);
        i_fe.conv(r, 1'b0, 1);
        rd_chk(`CSR_IDX_CLEAR_L, 8'h55, "clear back");
    endtask

    task automatic t_force();
        wr(`CSR_IDX_FORCE, 8'hA5);
        pin_chk(1'b1);
        rd_chk(`CSR_IDX_STATUS, 8'h01, "status force");
        wr(`CSR_IDX_CLR_CHAN, 8'h00);
        pin_chk(1'b1);
        wr(`CSR_IDX_CLR_ALL, 8'h00);
        pin_chk(1'b0);
    endtask

    task automatic t_persist();
        int n;
        wr(`CSR_IDX_LOW_THR_L, 8'h00);
        wr(`CSR_IDX_LOW_THR_H, 8'h01);
        wr(`CSR_IDX_HIGH_THR_L, 8'h00);
        wr(`CSR_IDX_HIGH_THR_H, 8'h80);
        in_r = r;
        in_r.clear = 16'h0200;
        out_r = r;
        for (int c = 0; c < 16; c++) begin
            n = (c < 4) ? ((c == 0) ? 1 : c) : ((c == 4) ? 5 : (c - 3) * 5);
            wr(`CSR_IDX_CLR_ALL, 8'h00);
            wr(`CSR_IDX_PERSIST, 8'(c));
            i_fe.conv(in_r, 1'b0, 1);
            if (c == 0) begin
                rd_chk(`CSR_IDX_STATUS, 8'h11, "every cycle");
            end else begin
                out_r.clear = c[0] ? 16'h0050 : 16'h9000;
                repeat (n - 1) i_fe.conv(out_r, 1'b0, 1);
                rd_chk(`CSR_IDX_STATUS, 8'h01, "below count");
                i_fe.conv(out_r, 1'b0, 1);
                rd_chk(`CSR_IDX_STATUS, 8'h11, "count met");
            end
        end
        wr(`CSR_IDX_CLR_ALL, 8'h00);
        wr(`CSR_IDX_PERSIST, 8'h01);
        out_r.clear = 16'h0100;
        i_fe.conv(out_r, 1'b0, 1);
        out_r.clear = 16'h8000;
        i_fe.conv(out_r, 1'b0, 2);
        rd_chk(`CSR_IDX_STATUS, 8'h01, "on bounds");
        out_r.clear = 16'h00FF;
        i_fe.conv(out_r, 1'b0, 1);
        rd_chk(`CSR_IDX_STATUS, 8'h11, "under low");
        pin_chk(1'b1);
        wr(`CSR_IDX_CLR_CHAN, 8'h00);
        rd_chk(`CSR_IDX_STATUS, 8'h01, "chan clear");
        pin_chk(1'b0);
    endtask

    task automatic t_sat();
        wr(`CSR_IDX_AUX, 8'h00);
        i_fe.conv(in_r, 1'b1, 1);
        rd_chk(`CSR_IDX_STATUS, 8'h81, "sat set");
        pin_chk(1'b0);
        wr(`CSR_IDX_AUX, 8'h20);
        pin_chk(1'b1);
        wr(`CSR_IDX_CLR_CHAN, 8'h00);
        rd_chk(`CSR_IDX_STATUS, 8'h01, "sat cleared");
        pin_chk(1'b0);
        i_fe.conv(in_r, 1'b1, 2);
        pin_chk(1'b1);
        wr(`CSR_IDX_ENABLE, 8'h00);
        rd_chk(`CSR_IDX_STATUS, 8'h00, "disabled");
        pin_chk(1'b0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_access();
        t_results();
        t_shadow();
        t_ir();
        t_force();
        t_persist();
        t_sat();
        end_of_test();
    end
endmodule
